// ### logic/homing_pkg.sv
// Constants, register map and types of the axis homing sequencer.
// Assumes one 100 MHz clock, APB register access and a motion stage outside.
// Behaviour
// - Homing active only when mode code six
// - Control bit four starts; clearing aborts
// - Status bits report progress, interrupted, confirmed, done
// - Error sets bit 13; standstill gives 101
// - Signed home offset held in user units
// - Separate switch search and zero search speeds
// - One acceleration for start and braking
// - Overrun past limit beyond band faults in search and index phases, not on block
// - Block detected when current exceeds threshold
// - Keep pushing block for set milliseconds
// - Method number picks source and direction
// - 1-14 use index; 17-30 ignore it
// - Negative method selects homing on block
// - Block homing only in closed loop
// - Methods 1/2: negative/positive limit plus index
// - Methods 3,4 left edge; 5,6 right edge
// - 7-10 positive limit, 11-14 negative limit
// - Method 17 negative, 18 positive limit
// - Methods 33/34 take next index only
// - Method 35 takes present position, unpowered
package homing_pkg;
	localparam logic [11:0] ADDR_MODE = 12'h000;
	localparam logic [11:0] ADDR_CONTROL = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_OFFSET = 12'h00C;
	localparam logic [11:0] ADDR_METHOD = 12'h010;
	localparam logic [11:0] ADDR_SPEED_SWITCH = 12'h014;
	localparam logic [11:0] ADDR_SPEED_ZERO = 12'h018;
	localparam logic [11:0] ADDR_ACCEL = 12'h01C;
	localparam logic [11:0] ADDR_BAND = 12'h020;
	localparam logic [11:0] ADDR_BLOCK_CURRENT = 12'h024;
	localparam logic [11:0] ADDR_BLOCK_TIME = 12'h028;
	localparam logic [11:0] ADDR_POSITION = 12'h02C;
	localparam logic [7:0] MODE_HOMING = 8'h06;
	localparam int CTRL_START_BIT = 4;
	localparam int STAT_BIT10 = 10;
	localparam int STAT_BIT12 = 12;
	localparam int STAT_BIT13 = 13;
	localparam int CLK_HZ = 100000000;
	localparam int MS_PER_S = 1000;
	localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
	localparam logic [31:0] CYCLES_PER_MS_W = 32'(CYCLES_PER_MS);
	localparam logic [7:0] METHOD_INDEX_LAST = 8'h0E;
	localparam logic [7:0] METHOD_NOIDX_FIRST = 8'h11;
	localparam logic [7:0] METHOD_NOIDX_LAST = 8'h1E;
	localparam logic [7:0] METHOD_NOIDX_SHIFT = 8'h10;
	localparam logic [7:0] METHOD_NEXT_INDEX_NEG = 8'h21;
	localparam logic [7:0] METHOD_NEXT_INDEX_POS = 8'h22;
	localparam logic [7:0] METHOD_PRESENT = 8'h23;
	localparam logic [2:0] ST_RUNNING = 3'h0;
	localparam logic [2:0] ST_IDLE = 3'h1;
	localparam logic [2:0] ST_CONFIRMED = 3'h2;
	localparam logic [2:0] ST_DONE = 3'h3;
	localparam logic [2:0] ST_ERR_MOVING = 3'h4;
	localparam logic [2:0] ST_ERR_STILL = 3'h5;
	// Reference source picked from the method code
	typedef enum {SRC_LIMIT, SRC_HOME_LEFT, SRC_HOME_RIGHT, SRC_INDEX, SRC_PRESENT} ref_src_t;
	// Decoded method: what to look for, which way, and whether an index follows
	typedef struct packed {
		logic valid;
		logic use_index;
		logic on_block;
		logic dir_pos;
		logic [2:0] src;
	} method_dec_t;
	// Inputs seen from the motion stage and sensors
	typedef struct packed {
		logic limit_neg;
		logic limit_pos;
		logic home_sw;
		logic index;
		logic standstill;
		logic closed_loop;
		logic op_enabled;
	} axis_in_t;
	// Motion command driven to the ramp generator
	typedef struct packed {
		logic run;
		logic dir_pos;
		logic [31:0] speed;
		logic [31:0] accel;
	} motion_cmd_t;
endpackage : homing_pkg

// ### logic/homing_method_dec.sv
// Decoder from the signed method code to search parameters.
// Assumes the code is stable while a run is in progress.
module homing_method_dec (
	input wire logic [7:0] method_i,
	output homing_pkg::method_dec_t dec_o
);
	import homing_pkg::*;
	wire logic neg = method_i[7];
	wire logic [7:0] mag = neg ? 8'(-method_i) : method_i;
	wire logic idx_range = (mag >= 8'h01) && (mag <= METHOD_INDEX_LAST);
	wire logic noidx_range = (mag >= METHOD_NOIDX_FIRST) && (mag <= METHOD_NOIDX_LAST);
	wire logic [7:0] base = noidx_range ? 8'(mag - METHOD_NOIDX_SHIFT) : mag;
	// Only 1,2 and 7..14 have a block variant, since 3..6 need no limit
	wire logic block_ok = (base <= 8'h02) || (base >= 8'h07);
	wire logic profile = idx_range || noidx_range;
	// Source and direction per travel profile
	wire logic [2:0] src_prof =
		(base <= 8'h02) ? 3'(SRC_LIMIT) :
		(base <= 8'h04) ? 3'(SRC_HOME_LEFT) :
		(base <= 8'h06) ? 3'(SRC_HOME_RIGHT) :
		(base[0] ? 3'(SRC_HOME_LEFT) : 3'(SRC_HOME_RIGHT));
	// Odd methods up to 6 start toward negative; 7..10 start toward the positive limit
	wire logic dir_prof = (base <= 8'h06) ? ~base[0] : (base <= 8'h0A);
	wire logic is_next_idx = !neg && ((mag == METHOD_NEXT_INDEX_NEG) || (mag == METHOD_NEXT_INDEX_POS));
	wire logic is_present = !neg && (mag == METHOD_PRESENT);
	assign dec_o.valid = profile ? (!neg || block_ok) : (is_next_idx || is_present);
	assign dec_o.use_index = idx_range || is_next_idx;
	assign dec_o.on_block = neg;
	assign dec_o.dir_pos = profile ? dir_prof : (mag == METHOD_NEXT_INDEX_POS);
	assign dec_o.src = profile ? src_prof : (is_next_idx ? 3'(SRC_INDEX) : 3'(SRC_PRESENT));
endmodule : homing_method_dec

// ### logic/homing_block_timer.sv
// Millisecond down-counter for the block dwell time.
// Assumes a 100 MHz clock; load restarts the count.
module homing_block_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [15:0] ms_i,
	output logic done_o
);
	import homing_pkg::*;
	logic [31:0] tick;
	logic [15:0] ms_left;
	logic active;
	// Prescaler gives one tick per millisecond
	always_ff @(posedge clk_i) begin
		if (rst_i || load_i) begin
			tick <= 32'h0;
			ms_left <= ms_i;
			active <= load_i;
			done_o <= 1'b0;
		end else if (active) begin
			done_o <= (ms_left == 16'h0);
			if (ms_left == 16'h0) begin
				active <= 1'b0;
			end else if (tick == CYCLES_PER_MS_W - 32'h1) begin
				tick <= 32'h0;
				ms_left <= ms_left - 16'h1;
			end else begin
				tick <= tick + 32'h1;
			end
		end else begin
			done_o <= 1'b0;
		end
	end
endmodule : homing_block_timer

// ### logic/axis_homing_sequencer.sv
// Top of the homing sequencer: APB registers, search state machine, outputs.
// Assumes sensor inputs synchronous to clk_i and a ramp generator that obeys the command.
module axis_homing_sequencer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire homing_pkg::axis_in_t axis_i,
	input wire logic [31:0] current_i,
	input wire logic signed [31:0] pos_i,
	output homing_pkg::motion_cmd_t cmd_o,
	output logic pos_load_o,
	output logic signed [31:0] pos_load_val_o,
	output logic fault_o
);
	import homing_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] mode;
	logic [15:0] control;
	logic signed [31:0] home_offset;
	logic [7:0] method;
	logic [31:0] speed_switch;
	logic [31:0] speed_zero;
	logic [31:0] accel;
	logic [31:0] band;
	logic [31:0] block_current;
	logic [15:0] block_ms;
	logic [2:0] stat;

	typedef enum {S_IDLE, S_SEARCH, S_BACKOFF, S_INDEX, S_BLOCK_DWELL, S_SETTLE, S_DONE, S_ERR} state_t;
	state_t state;
	state_t next_state;

	// APB decode: one wait-free access phase
	wire logic acc = psel_i && penable_i;
	wire logic wr = acc && pwrite_i;
	wire logic mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= ADDR_POSITION);
	wire logic homing_mode = (mode == MODE_HOMING);
	wire logic start_bit = control[CTRL_START_BIT];
	wire logic [15:0] status_word = {2'h0, stat[2], stat[1], 1'b0, stat[0], 10'h0};

	// Read mux
	wire logic [31:0] rd_val =
		(paddr_i == ADDR_MODE) ? {24'h0, mode} :
		(paddr_i == ADDR_CONTROL) ? {16'h0, control} :
		(paddr_i == ADDR_STATUS) ? {16'h0, status_word} :
		(paddr_i == ADDR_OFFSET) ? home_offset :
		(paddr_i == ADDR_METHOD) ? {{24{method[7]}}, method} :
		(paddr_i == ADDR_SPEED_SWITCH) ? speed_switch :
		(paddr_i == ADDR_SPEED_ZERO) ? speed_zero :
		(paddr_i == ADDR_ACCEL) ? accel :
		(paddr_i == ADDR_BAND) ? band :
		(paddr_i == ADDR_BLOCK_CURRENT) ? block_current :
		(paddr_i == ADDR_BLOCK_TIME) ? {16'h0, block_ms} :
		(paddr_i == ADDR_POSITION) ? pos_i : 32'h0;

	// Answer every access in its first access cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !mapped;
			prdata_o <= rd_val;
		end
	end

	// Write decode gated by the ready phase so each write lands once
	wire logic wr_ok = wr && pready_o && mapped;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= 8'h0;
			control <= 16'h0;
			home_offset <= 32'sh0;
			method <= 8'h0;
			speed_switch <= 32'h0;
			speed_zero <= 32'h0;
			accel <= 32'h0;
			band <= 32'h0;
			block_current <= 32'h0;
			block_ms <= 16'h0;
		end else if (wr_ok) begin
			if (paddr_i == ADDR_MODE) mode <= pwdata_i[7:0];
			if (paddr_i == ADDR_CONTROL) control <= pwdata_i[15:0];
			if (paddr_i == ADDR_OFFSET) home_offset <= pwdata_i;
			if (paddr_i == ADDR_METHOD) method <= pwdata_i[7:0];
			if (paddr_i == ADDR_SPEED_SWITCH) speed_switch <= pwdata_i;
			if (paddr_i == ADDR_SPEED_ZERO) speed_zero <= pwdata_i;
			if (paddr_i == ADDR_ACCEL) accel <= pwdata_i;
			if (paddr_i == ADDR_BAND) band <= pwdata_i;
			if (paddr_i == ADDR_BLOCK_CURRENT) block_current <= pwdata_i;
			if (paddr_i == ADDR_BLOCK_TIME) block_ms <= pwdata_i[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Method decode and dwell timer
	method_dec_t dec;
	homing_method_dec u_dec (
		.method_i(method),
		.dec_o(dec)
	);
	logic dwell_load;
	logic dwell_done;
	homing_block_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(dwell_load),
		.ms_i(block_ms),
		.done_o(dwell_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Sensing
	logic dir;
	logic home_q;
	logic signed [31:0] limit_pos_at;
	wire logic block_hit = current_i > block_current;
	wire logic limit_ahead = dir ? axis_i.limit_pos : axis_i.limit_neg;
	// A block stands in for the limit switch in block methods
	wire logic end_hit = dec.on_block ? block_hit : limit_ahead;
	wire logic home_rise = axis_i.home_sw && !home_q;
	wire logic home_fall = !axis_i.home_sw && home_q;
	wire logic [2:0] src = dec.src;
	// Left edge shows as a rise moving positive and a fall moving negative; right edge the reverse
	wire logic edge_seen = (src == 3'(SRC_HOME_LEFT)) ? (dir ? home_rise : home_fall) :
		(dir ? home_fall : home_rise);
	wire logic signed [31:0] travel = pos_i - limit_pos_at;
	wire logic [31:0] overrun = travel[31] ? 32'(-travel) : 32'(travel);
	// Overrun is watched on either limit, since the axis coasts on past it after a reversal
	wire logic limit_any = axis_i.limit_pos || axis_i.limit_neg;
	wire logic band_exceeded = limit_any && !dec.on_block && (overrun > band);
	// Runs allowed: block needs closed loop, all need power except method 35
	wire logic start_ok = dec.valid && (!dec.on_block || axis_i.closed_loop) &&
		(axis_i.op_enabled || src == 3'(SRC_PRESENT));
	wire logic aborted = !start_bit || !homing_mode;

	// Next-state logic of the search
	always_comb begin
		next_state = state;
		dwell_load = 1'b0;
		case (state)
			S_IDLE: begin
				if (homing_mode && start_bit) begin
					if (!start_ok) next_state = S_ERR;
					else if (src == 3'(SRC_PRESENT)) next_state = S_DONE;
					else if (src == 3'(SRC_INDEX)) next_state = S_INDEX;
					else next_state = S_SEARCH;
				end
			end
			S_SEARCH: begin
				if (aborted) next_state = S_IDLE;
				else if (band_exceeded) next_state = S_ERR;
				else if (src == 3'(SRC_LIMIT) && end_hit) begin
					if (dec.on_block) begin
						next_state = S_BLOCK_DWELL;
						dwell_load = 1'b1;
					end else begin
						next_state = dec.use_index ? S_INDEX : S_SETTLE;
					end
				end else if (src != 3'(SRC_LIMIT) && edge_seen) begin
					next_state = dec.use_index ? S_INDEX : S_SETTLE;
				end else if (src != 3'(SRC_LIMIT) && end_hit) begin
					next_state = S_BACKOFF;
				end
			end
			S_BACKOFF: begin
				if (aborted) next_state = S_IDLE;
				else if (!end_hit) next_state = S_SEARCH;
			end
			S_BLOCK_DWELL: begin
				if (aborted) next_state = S_IDLE;
				else if (dwell_done) next_state = dec.use_index ? S_INDEX : S_SETTLE;
			end
			S_INDEX: begin
				if (aborted) next_state = S_IDLE;
				else if (band_exceeded) next_state = S_ERR;
				else if (axis_i.index) next_state = S_SETTLE;
			end
			S_SETTLE: begin
				if (aborted) next_state = S_IDLE;
				else if (axis_i.standstill) next_state = S_DONE;
			end
			S_DONE: begin
				if (!start_bit) next_state = S_IDLE;
			end
			S_ERR: begin
				if (!start_bit) next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
	end

	// Reference is taken on entry into the settling phase
	wire logic take_ref = (next_state == S_SETTLE && state != S_SETTLE) ||
		(next_state == S_DONE && state == S_IDLE);
	// A block ends the outward run like a limit, so the index is sought on the way back
	wire logic reverse = (state == S_SEARCH && next_state == S_BACKOFF) ||
		(state == S_SEARCH && next_state == S_INDEX && src == 3'(SRC_LIMIT)) ||
		(state == S_BLOCK_DWELL && next_state == S_INDEX);
	wire logic moving = (state == S_SEARCH) || (state == S_BACKOFF) ||
		(state == S_INDEX) || (state == S_BLOCK_DWELL);

	////////////////////////////////////////////////////////////////////////
	// State, direction and sensor history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= S_IDLE;
			dir <= 1'b0;
			home_q <= 1'b0;
			limit_pos_at <= 32'sh0;
		end else begin
			state <= next_state;
			home_q <= axis_i.home_sw;
			if (state == S_IDLE) dir <= dec.dir_pos;
			else if (reverse) dir <= ~dir;
			if (!limit_any) limit_pos_at <= pos_i;
		end
	end

	// Status code: done holds in mode 6 once bit 4 clears; a new start drops it so no poll sees a stale done
	wire logic [2:0] next_stat =
		(state == S_ERR) ? (axis_i.standstill ? ST_ERR_STILL : ST_ERR_MOVING) :
		(state == S_DONE) ? ST_DONE :
		(state == S_SETTLE) ? ST_CONFIRMED :
		(state == S_IDLE) ? ((stat == ST_DONE && homing_mode && !start_bit) ? ST_DONE : ST_IDLE) :
		ST_RUNNING;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat <= ST_IDLE;
			cmd_o <= '0;
			pos_load_o <= 1'b0;
			pos_load_val_o <= 32'sh0;
			fault_o <= 1'b0;
		end else begin
			stat <= next_stat;
			cmd_o.run <= moving && next_state != S_ERR;
			cmd_o.dir_pos <= dir;
			cmd_o.speed <= (state == S_INDEX) ? speed_zero : speed_switch;
			cmd_o.accel <= accel;
			pos_load_o <= take_ref;
			pos_load_val_o <= home_offset;
			fault_o <= (next_state == S_ERR) && band_exceeded ? 1'b1 : (start_bit ? fault_o : 1'b0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_status_err;
		@(posedge clk_i) disable iff (rst_i) state == S_ERR |=> stat[2] == 1'b1;
	endproperty
	a_status_err: assert property (p_status_err) else $error("error state without bit 13");
	property p_mode_gate;
		@(posedge clk_i) disable iff (rst_i) (state == S_IDLE && !homing_mode) |=> state == S_IDLE;
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("homing left idle outside mode 6");
	property p_abort;
		@(posedge clk_i) disable iff (rst_i) (moving && !start_bit) |=> state == S_IDLE ##1 !cmd_o.run;
	endproperty
	a_abort: assert property (p_abort) else $error("clearing bit 4 did not abort");
	property p_ref_load;
		@(posedge clk_i) disable iff (rst_i) take_ref |=> pos_load_o && pos_load_val_o == $past(home_offset);
	endproperty
	a_ref_load: assert property (p_ref_load) else $error("reference not loaded with offset");
	property p_speed_zero;
		@(posedge clk_i) disable iff (rst_i) state == S_INDEX |=> cmd_o.speed == $past(speed_zero);
	endproperty
	a_speed_zero: assert property (p_speed_zero) else $error("index search speed wrong");
	property p_band;
		@(posedge clk_i) disable iff (rst_i) ((state == S_SEARCH || state == S_INDEX) && band_exceeded &&
			start_bit && homing_mode)
			|=> state == S_ERR ##1 fault_o;
	endproperty
	a_band: assert property (p_band) else $error("band overrun did not fault");
	property p_block_loop;
		@(posedge clk_i) disable iff (rst_i) state == S_BLOCK_DWELL |-> axis_i.closed_loop || $past(state) == S_BLOCK_DWELL;
	endproperty
	a_block_loop: assert property (p_block_loop) else $error("block homing entered in open loop");
	property p_accel;
		@(posedge clk_i) disable iff (rst_i) ##1 cmd_o.accel == $past(accel);
	endproperty
	a_accel: assert property (p_accel) else $error("homing acceleration not passed");
	property p_present;
		@(posedge clk_i) disable iff (rst_i) (state == S_IDLE && next_state == S_DONE) |=> ##1 stat == ST_DONE;
	endproperty
	a_present: assert property (p_present) else $error("method 35 did not complete");
	c_done: cover property (@(posedge clk_i) disable iff (rst_i) state == S_SETTLE ##1 state == S_DONE);
	c_err: cover property (@(posedge clk_i) disable iff (rst_i) state == S_ERR);
	c_dwell: cover property (@(posedge clk_i) disable iff (rst_i) state == S_BLOCK_DWELL ##1 state == S_INDEX);
	c_backoff: cover property (@(posedge clk_i) disable iff (rst_i) state == S_BACKOFF);
endmodule : axis_homing_sequencer

// ### tb/axis_stage_model.sv
// Behavioural motion stage: axis, switches, encoder index and block current.
// Assumes one step of travel per cycle while running and a fixed coast delay.
module axis_stage_model import homing_pkg::*; #(
	parameter int COAST = 4,
	parameter int LIM = 40,
	parameter int BLK = 50
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire homing_pkg::motion_cmd_t cmd_i,
	input wire logic pos_load_i,
	input wire logic signed [31:0] pos_load_val_i,
	input wire logic sw_en_i,
	input wire logic closed_loop_i,
	input wire logic op_enabled_i,
	output homing_pkg::axis_in_t axis_o,
	output logic [31:0] current_o,
	output logic signed [31:0] pos_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [COAST-1:0] run_q;
	logic [COAST-1:0] dir_q;
	wire logic mv = run_q[COAST-1];
	wire logic dir = dir_q[COAST-1];
	wire logic at_blk = mv && (dir ? pos_o >= BLK : pos_o <= -BLK);
	////////////////////////////////////////////////////////////////////////////
	// Travel lags the command, so braking overruns any switch it meets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q <= '0;
			dir_q <= '0;
			pos_o <= 32'sh0;
		end else begin
			run_q <= {run_q[COAST-2:0], cmd_i.run};
			dir_q <= {dir_q[COAST-2:0], cmd_i.dir_pos};
			if (pos_load_i) begin
				pos_o <= pos_load_val_i;
			end else if (mv && !at_blk) begin
				pos_o <= dir ? pos_o + 1 : pos_o - 1;
			end
		end
	end
	// Switch inputs read inactive unless configured as switches
	assign axis_o.limit_neg = sw_en_i && pos_o <= -LIM;
	assign axis_o.limit_pos = sw_en_i && pos_o >= LIM;
	assign axis_o.home_sw = sw_en_i && pos_o >= 10 && pos_o < 20;
	assign axis_o.index = pos_o[2:0] == 3'h0;
	assign axis_o.standstill = !(|run_q) && !cmd_i.run;
	assign axis_o.closed_loop = closed_loop_i;
	assign axis_o.op_enabled = op_enabled_i;
	// Pushing against the mechanical end raises the current
	assign current_o = at_blk ? 32'h00000100 : 32'h00000010;
endmodule : axis_stage_model

// ### tb/axis_homing_sequencer_tb.sv
// Self-checking bench of the homing sequencer, driven over APB.
// Assumes the stage model in axis_stage_model and no APB wait states beyond pready.
module axis_homing_sequencer_tb import homing_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, current;
	logic pready, pslverr, pos_load, fault, sw_en, cl, op_en;
	logic signed [31:0] pos, pos_load_val, last_load;
	axis_in_t axis;
	motion_cmd_t cmd;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	int n_load = 0;
	int n0;
	logic [31:0] r;
	logic e;
	logic [7:0] bad [5] = '{8'h0F, 8'h10, 8'h1F, 8'hFD, 8'h24};
	axis_homing_sequencer i_axis_homing_sequencer (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .axis_i(axis), .current_i(current), .pos_i(pos),
		.cmd_o(cmd), .pos_load_o(pos_load), .pos_load_val_o(pos_load_val), .fault_o(fault));
	axis_stage_model i_axis_stage_model (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .pos_load_i(pos_load),
		.pos_load_val_i(pos_load_val), .sw_en_i(sw_en), .closed_loop_i(cl), .op_enabled_i(op_en),
		.axis_o(axis), .current_o(current), .pos_o(pos));
	////////////////////////////////////////////////////////////////////////////
	// Clock, cycle ceiling and reference-load monitor
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			n_fail++;
			summarize();
		end
	end
	always @(posedge clk_i) begin
		if (pos_load === 1'b1) begin
			n_load <= n_load + 1;
			last_load <= pos_load_val;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic summarize();
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held from setup until the edge where pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic err;
		apb(1'b1, a, d, q, err);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic err;
		apb(1'b0, a, 32'h0, q, err);
	endtask : rd
	function automatic logic [2:0] code(input logic [31:0] s);
		return {s[STAT_BIT13], s[STAT_BIT12], s[STAT_BIT10]};
	endfunction : code
	// Polls status until the wanted code shows or the read budget runs out
	task automatic wait_code(input logic [2:0] want, input int lim);
		logic [31:0] s;
		int i;
		i = 0;
		rd(ADDR_STATUS, s);
		while (code(s) !== want && i < lim) begin
			rd(ADDR_STATUS, s);
			i++;
		end
		chk({29'h0, code(s)}, {29'h0, want});
	endtask : wait_code
	task automatic start(input logic [7:0] m);
		wr(ADDR_METHOD, {{24{m[7]}}, m});
		wr(ADDR_CONTROL, 32'h00000010);
	endtask : start
	task automatic go(input logic [7:0] m, input logic [2:0] want);
		start(m);
		wait_code(want, 300);
		wr(ADDR_CONTROL, 32'h0);
	endtask : go
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_i <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		sw_en <= 1'b1;
		cl <= 1'b1;
		op_en <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wait_code(ST_IDLE, 0);
		// Unmapped and unaligned places are refused and read zero
		apb(1'b0, 12'h0FC, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h80000000);
		apb(1'b1, 12'h002, 32'h5, r, e);
		chk({31'h0, e}, 32'h1);
		wr(ADDR_OFFSET, 32'hFFFFFFF3);
		rd(ADDR_OFFSET, r);
		chk(r, 32'hFFFFFFF3);
		wr(ADDR_METHOD, 32'h000000EF);
		rd(ADDR_METHOD, r);
		chk(r, 32'hFFFFFFEF);
		wr(ADDR_SPEED_SWITCH, 32'h5);
		wr(ADDR_SPEED_ZERO, 32'h3);
		wr(ADDR_ACCEL, 32'h7);
		wr(ADDR_BAND, 32'h64);
		wr(ADDR_BLOCK_CURRENT, 32'h80);
		wr(ADDR_BLOCK_TIME, 32'h0);
		// Start bit without the homing mode must not move the axis
		wr(ADDR_MODE, 32'h0);
		start(8'h23);
		repeat (4) @(posedge clk_i);
		chk({31'h0, cmd.run}, 32'h0);
		wait_code(ST_IDLE, 0);
		wr(ADDR_CONTROL, 32'h0);
		wr(ADDR_MODE, {24'h0, MODE_HOMING});
		go(8'h23, ST_DONE);
		chk(last_load, 32'hFFFFFFF3);
		rd(ADDR_POSITION, r);
		chk(r, 32'hFFFFFFF3);
		op_en <= 1'b1;
		// Index-only search runs at the zero speed in the coded direction
		start(8'h22);
		repeat (2) @(posedge clk_i);
		chk({cmd.run, cmd.dir_pos, cmd.speed[29:0]}, {2'b11, 30'h3});
		wait_code(ST_DONE, 300);
		wr(ADDR_CONTROL, 32'h0);
		go(8'h21, ST_DONE);
		start(8'h11);
		repeat (2) @(posedge clk_i);
		chk({cmd.run, cmd.dir_pos, cmd.speed[29:0]}, {2'b10, 30'h5});
		chk(cmd.accel, 32'h7);
		wait_code(ST_RUNNING, 0);
		wait_code(ST_DONE, 300);
		wr(ADDR_CONTROL, 32'h0);
		start(8'h12);
		repeat (2) @(posedge clk_i);
		chk({30'h0, cmd.run, cmd.dir_pos}, 32'h3);
		wait_code(ST_DONE, 300);
		wr(ADDR_CONTROL, 32'h0);
		// Every switch and index method must complete and load the reference
		n0 = n_load;
		for (int m = 1; m <= 30; m++) begin
			if (m < 15 || m > 16) begin
				go(8'(m), ST_DONE);
			end
		end
		chk(32'(n_load - n0), 32'h1C);
		// Abort in mid-run
		start(8'h02);
		@(posedge clk_i);
		wr(ADDR_CONTROL, 32'h0);
		wait_code(ST_IDLE, 20);
		chk({31'h0, cmd.run}, 32'h0);
		for (int i = 0; i < 5; i++) begin
			go(bad[i], ST_ERR_STILL);
		end
		// A narrow band is overrun by braking at the limit
		go(8'h12, ST_DONE);
		wr(ADDR_BAND, 32'h1);
		start(8'h01);
		for (int i = 0; i < 400 && fault !== 1'b1; i++) @(posedge clk_i);
		chk({31'h0, fault}, 32'h1);
		wait_code(ST_ERR_STILL, 50);
		wr(ADDR_CONTROL, 32'h0);
		@(posedge clk_i);
		chk({31'h0, fault}, 32'h0);
		wr(ADDR_BAND, 32'h64);
		// Homing on block: refused open loop, then found by current
		sw_en <= 1'b0;
		cl <= 1'b0;
		go(8'hEF, ST_ERR_STILL);
		cl <= 1'b1;
		n0 = n_load;
		go(8'hEF, ST_DONE);
		go(8'hEE, ST_DONE);
		go(8'hFF, ST_DONE);
		chk(32'(n_load - n0), 32'h3);
		summarize();
	end
endmodule : axis_homing_sequencer_tb
